// ==== verilog/tsp_top.sv ====
// transmit slot provisioning register bank with clock activity monitors
`timescale 1ns/1ps
`include "tsp_cfg.svh"
module tsp_top import tsp_pkg::*; #(
   parameter int LINKS = 32,
   parameter int TW = 7,
   parameter int FW = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // transmit link clock pins
   input wire logic [LINKS-1:0] tx_link_clock,
   // monitor status
   output logic [LINKS-1:0] framing_det,
   output logic [LINKS-1:0] byte_start,
   // slot lookup from the data path
   input wire logic lk_valid,
   input wire logic [4:0] lk_link,
   input wire logic [4:0] lk_slot,
   input wire logic [FW-1:0] channel_number_byte,
   // slot lookup answer, two cycles later
   output logic lk_out_valid,
   output logic lk_assigned,
   output logic [6:0] lk_channel,
   output logic [FW-1:0] tx_link_data
);
   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic dp_wr_q;
   logic [`TSP_OFS_W-1:0] dp_addr_q;
   logic [31:0] rdata_q;
   // hready is part of the take condition, so a stalled transfer is never counted twice
   wire logic ap = hsel & htrans[1] & hready;
   wire logic [`TSP_OFS_W-1:0] ap_addr = haddr[`TSP_OFS_W-1:0];

   // address phase is registered; writes land in the data phase
   always_ff @(posedge clock) begin
      if (rst) begin
         dp_wr_q <= 1'b0;
         dp_addr_q <= '0;
      end else begin
         dp_wr_q <= ap & hwrite;
         dp_addr_q <= ap_addr;
      end
   end

   // every transfer completes at once with an okay answer
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   // write strobes per register
   wire logic w_sel = dp_wr_q & (dp_addr_q == `TSP_OFS_SEL);
   wire logic w_dat = dp_wr_q & (dp_addr_q == `TSP_OFS_DATA);
   wire logic w_thr = dp_wr_q & (dp_addr_q == `TSP_OFS_THR);
   wire logic w_fill = dp_wr_q & (dp_addr_q == `TSP_OFS_FILL);
   wire logic w_bs = dp_wr_q & (dp_addr_q == `TSP_OFS_BYTE_SYNC_ENABLE);
   wire logic w_cen = dp_wr_q & (dp_addr_q == `TSP_OFS_CEN);
   wire logic w_e1 = dp_wr_q & (dp_addr_q == `TSP_OFS_E1);

   // ---------------------------------------------------------------
   // indirect access sequencer
   // ---------------------------------------------------------------
   tsp_acc_state_t state_q, state_d;
   logic dir_q;
   tsp_addr_t acc_q;
   tsp_entry_t hold_q, data_q;
   tsp_entry_t ram_a_data, ram_b_data;
   // busy is decoded from the state, so it can never disagree with the sequencer
   wire logic busy = (state_q != tsp_st_idle);
   wire logic start = w_sel & ~busy;
   wire logic new_dir = hwdata[`TSP_DIR_BIT];
   wire tsp_addr_t new_addr = '{slot: hwdata[`TSP_SLOT_LSB +: 5], link: hwdata[`TSP_LINK_LSB +: 5]};
   wire tsp_entry_t sw_entry = '{assigned: hwdata[`TSP_SLOT_ASSIGNED_FLAG_BIT], channel_number: hwdata[`TSP_CHANNEL_NUMBER_LSB +: 7]};

   // write takes one busy cycle, read takes two (memory read, capture)
   always_comb begin
      state_d = state_q;
      case (state_q)
         tsp_st_idle: begin
            if (start) begin
               state_d = new_dir ? tsp_st_rd : tsp_st_wr;
            end
         end
         tsp_st_wr: begin
            state_d = tsp_st_idle;
         end
         tsp_st_rd: begin
            state_d = tsp_st_cap;
         end
         tsp_st_cap: begin
            state_d = tsp_st_idle;
         end
         default: begin
            state_d = tsp_st_idle;
         end
      endcase
   end

   // sequencer state and the latched select fields
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= tsp_st_idle;
         dir_q <= 1'b0;
         acc_q <= '0;
         hold_q <= '0;
      end else begin
         state_q <= state_d;
         if (start) begin
            dir_q <= new_dir;
            acc_q <= new_addr;
            hold_q <= data_q;
         end
      end
   end

   // a completing read wins over a software write in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         data_q <= '0;
      end else if (state_q == tsp_st_cap) begin
         data_q <= ram_a_data;
      end else if (w_dat) begin
         data_q <= sw_entry;
      end
   end

   // the entry is written in the single busy cycle of a write access
   wire logic ram_we = (state_q == tsp_st_wr);
   // lookup address uses the same slot-over-link packing as the host port
   wire tsp_addr_t lk_addr = '{slot: lk_slot, link: lk_link};
   // port a serves the host, port b the data path; both read through a register
   tsp_slot_assigned_flag_ram #(
      .AW(10)
   ) u_ram (
      .clock(clock),
      .wr_en(ram_we),
      .wr_addr(acc_q),
      .wr_data(hold_q),
      .rd_a_addr(acc_q),
      .rd_a_data(ram_a_data),
      .rd_b_addr(lk_addr),
      .rd_b_data(ram_b_data)
   );

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   logic [TW-1:0] thr_q;
   logic [FW-1:0] fill_q;
   logic [LINKS-1:0] byte_sync_enable_q, cen_q, e1_q;

   // software settings and their reset values
   // the threshold is not range checked: keeping it within 1 to 126 is left to software
   always_ff @(posedge clock) begin
      if (rst) begin
         thr_q <= `TSP_THR_RST;
         fill_q <= `TSP_FILL_RST;
         byte_sync_enable_q <= '0;
         cen_q <= '0;
         e1_q <= '0;
      end else begin
         if (w_thr) thr_q <= hwdata[TW-1:0];
         if (w_fill) fill_q <= hwdata[FW-1:0];
         if (w_bs) byte_sync_enable_q <= hwdata[LINKS-1:0];
         if (w_cen) cen_q <= hwdata[LINKS-1:0];
         if (w_e1) e1_q <= hwdata[LINKS-1:0];
      end
   end

   // ---------------------------------------------------------------
   // read mux, sampled in the address phase
   // ---------------------------------------------------------------
   wire logic [31:0] sel_rd = 32'(busy) << `TSP_BUSY_BIT | 32'(dir_q) << `TSP_DIR_BIT
      | 32'(acc_q.link) << `TSP_LINK_LSB | 32'(acc_q.slot) << `TSP_SLOT_LSB;
   wire logic [31:0] dat_rd = 32'(data_q.assigned) << `TSP_SLOT_ASSIGNED_FLAG_BIT | 32'(data_q.channel_number) << `TSP_CHANNEL_NUMBER_LSB;
   wire logic [31:0] rd_mux =
      (ap_addr == `TSP_OFS_SEL) ? sel_rd :
      (ap_addr == `TSP_OFS_DATA) ? dat_rd :
      (ap_addr == `TSP_OFS_THR) ? 32'(thr_q) :
      (ap_addr == `TSP_OFS_FILL) ? 32'(fill_q) :
      (ap_addr == `TSP_OFS_BYTE_SYNC_ENABLE) ? 32'(byte_sync_enable_q) :
      (ap_addr == `TSP_OFS_CEN) ? 32'(cen_q) :
      (ap_addr == `TSP_OFS_E1) ? 32'(e1_q) :
      (ap_addr == `TSP_OFS_DET) ? 32'(framing_det) : 32'h0000_0000;

   // unmapped addresses read as zero
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (ap & ~hwrite) begin
         rdata_q <= rd_mux;
      end
   end

   // ---------------------------------------------------------------
   // clock activity monitors, one per link
   // ---------------------------------------------------------------
   // each link keeps its own counter; only the threshold is shared
   for (genvar i = 0; i < LINKS; i++) begin : g_mon
      tsp_link_mon #(
         .CW(TW)
      ) u_mon (
         .clock(clock),
         .rst(rst),
         .tx_link_clock(tx_link_clock[i]),
         .byte_sync_enable(byte_sync_enable_q[i]),
         .channelise_enable(cen_q[i]),
         .framing_gap_threshold(thr_q),
         .framing_det(framing_det[i]),
         .byte_start(byte_start[i])
      );
   end

   // ---------------------------------------------------------------
   // slot lookup for the data path
   // ---------------------------------------------------------------
   // a slot illegal for the link's mode always sends fill, whatever its entry holds
   wire logic lk_cen = cen_q[lk_link];
   wire logic [4:0] lk_last = e1_q[lk_link] ? `TSP_SLOT_E1_LAST : `TSP_SLOT_T1_LAST;
   wire logic lk_ok = lk_cen ? (lk_slot >= `TSP_SLOT_FIRST && lk_slot <= lk_last)
      : (lk_slot == `TSP_SLOT_UNCH);
   logic v1_q, ok1_q;
   logic [FW-1:0] byte1_q;
   wire logic use_channel_number = ram_b_data.assigned & ok1_q;

   // stage one waits on the memory; stage two picks channel data or fill
   always_ff @(posedge clock) begin
      if (rst) begin
         v1_q <= 1'b0;
         ok1_q <= 1'b0;
         byte1_q <= '0;
         lk_out_valid <= 1'b0;
         lk_assigned <= 1'b0;
         lk_channel <= '0;
         tx_link_data <= '0;
      end else begin
         v1_q <= lk_valid;
         ok1_q <= lk_ok;
         byte1_q <= channel_number_byte;
         lk_out_valid <= v1_q;
         lk_assigned <= use_channel_number;
         lk_channel <= ram_b_data.channel_number;
         tx_link_data <= use_channel_number ? byte1_q : fill_q;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // a write access holds busy for one cycle, a read for two
   sequence wr_access;
      busy ##1 ~busy;
   endsequence
   sequence rd_access;
      busy [*2] ##1 ~busy;
   endsequence
   busy_write_a: assert property (start & ~new_dir |=> wr_access)
      else $error("write access busy length wrong");
   busy_read_a: assert property (start & new_dir |=> rd_access)
      else $error("read access busy length wrong");
   addr_form_a: assert property (start |=> acc_q ==
      {$past(hwdata[`TSP_SLOT_LSB +: 5]), $past(hwdata[`TSP_LINK_LSB +: 5])})
      else $error("memory address not slot over link");
   hold_copy_a: assert property (start |=> hold_q == $past(data_q))
      else $error("holding register not loaded");
   busy_ignore_a: assert property (busy & w_sel |=> $stable(acc_q) && $stable(dir_q))
      else $error("select written while busy");
   rd_result_a: assert property (state_q == tsp_st_rd ##1 state_q == tsp_st_cap
      |=> data_q == $past(ram_a_data))
      else $error("read result not placed in data register");
   data_keep_a: assert property (~w_dat & state_q != tsp_st_cap |=> $stable(data_q))
      else $error("data register changed without cause");
   fill_out_a: assert property (lk_valid & ~lk_ok ##2 1'b1 |-> tx_link_data == $past(fill_q))
      else $error("invalid slot not filled with idle byte");
   // busy only ever rises from an accepted select write
   busy_cause_a: assert property ($rose(busy) |-> $past(start))
      else $error("busy rose without an accepted select write");
   // a software data write lands unless a read completes in the same cycle
   data_wr_a: assert property (w_dat & state_q != tsp_st_cap |=> data_q == $past(sw_entry))
      else $error("software value not held in data register");
   // the memory is written only by a write access started the cycle before
   ram_write_a: assert property (ram_we |-> $past(start) && !$past(new_dir))
      else $error("memory written without a write access");
   read_no_write_a: assert property (start & new_dir |=> ~ram_we [*3])
      else $error("read access wrote the memory");
   // reset values of the fill byte and the threshold
   rst_value_a: assert property ($fell(rst) |-> fill_q == `TSP_FILL_RST && thr_q == `TSP_THR_RST)
      else $error("fill byte or threshold reset value wrong");

   // ---------------------------------------------------------------
   // lookup checks; the answer stands two edges after the request
   // ---------------------------------------------------------------
   sequence lk_legal;
      lk_valid & lk_ok ##2 1'b1;
   endsequence
   sequence lk_illegal;
      lk_valid & ~lk_ok ##2 1'b1;
   endsequence
   lk_pipe_a: assert property (lk_valid |-> ##2 lk_out_valid)
      else $error("lookup answer missing two cycles after request");
   channel_number_pass_a: assert property (lk_legal
      |-> tx_link_data == (lk_assigned ? $past(channel_number_byte, 2) : $past(fill_q)))
      else $error("legal slot carried the wrong byte");
   bad_slot_a: assert property (lk_illegal |-> ~lk_assigned)
      else $error("illegal slot marked as assigned");
endmodule // tsp_top

// ==== verilog/tsp_cfg.svh ====
// offsets, field positions, reset values and limits of the slot provisioning block
`ifndef TSP_CFG_SVH
`define TSP_CFG_SVH
// ---------------------------------------------------------------
// register byte offsets (low twelve address bits)
// ---------------------------------------------------------------
`define TSP_OFS_SEL 12'h400
`define TSP_OFS_DATA 12'h404
`define TSP_OFS_THR 12'h408
`define TSP_OFS_FILL 12'h40C
`define TSP_OFS_BYTE_SYNC_ENABLE 12'h420
`define TSP_OFS_CEN 12'h424
`define TSP_OFS_E1 12'h428
`define TSP_OFS_DET 12'h42C
`define TSP_OFS_W 12
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TSP_BUSY_BIT 15
`define TSP_DIR_BIT 14
`define TSP_LINK_LSB 8
`define TSP_SLOT_LSB 0
`define TSP_SLOT_ASSIGNED_FLAG_BIT 8
`define TSP_CHANNEL_NUMBER_LSB 0
// ---------------------------------------------------------------
// reset values and slot limits
// ---------------------------------------------------------------
`define TSP_THR_RST 7'h1F
`define TSP_FILL_RST 8'hFF
`define TSP_SLOT_FIRST 5'h01
`define TSP_SLOT_T1_LAST 5'h18
`define TSP_SLOT_E1_LAST 5'h1F
`define TSP_SLOT_UNCH 5'h00
`define TSP_EDGE_LAST 2'h3
`endif

// ==== verilog/tsp_pkg.sv ====
// types shared by the slot provisioning block
package tsp_pkg;
   // indirect access sequencer
   typedef enum logic [1:0] {
      tsp_st_idle = 2'b00,
      tsp_st_wr = 2'b01,
      tsp_st_rd = 2'b10,
      tsp_st_cap = 2'b11
   } tsp_acc_state_t;
   // one provisioning entry
   typedef struct packed {
      logic assigned;
      logic [6:0] channel_number;
   } tsp_entry_t;
   // provisioning address: slot above link
   typedef struct packed {
      logic [4:0] slot;
      logic [4:0] link;
   } tsp_addr_t;
endpackage

// ==== verilog/tsp_slot_assigned_flag_ram.sv ====
// provisioning memory: one write port, two registered read ports
`timescale 1ns/1ps
module tsp_slot_assigned_flag_ram import tsp_pkg::*; #(
   parameter int AW = 10
) (
   // clock
   input wire logic clock,
   // write port
   input wire logic wr_en,
   input wire tsp_addr_t wr_addr,
   input wire tsp_entry_t wr_data,
   // host read port
   input wire tsp_addr_t rd_a_addr,
   output tsp_entry_t rd_a_data,
   // lookup read port
   input wire tsp_addr_t rd_b_addr,
   output tsp_entry_t rd_b_data
);
   tsp_entry_t mem [0:(1<<AW)-1];

   // contents are undefined until software provisions them
   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
   end
endmodule // tsp_slot_assigned_flag_ram

// ==== verilog/tsp_link_mon.sv ====
// clock activity monitor of one transmit link
`timescale 1ns/1ps
`include "tsp_cfg.svh"
module tsp_link_mon import tsp_pkg::*; #(
   parameter int CW = 7
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // link clock pin
   input wire logic tx_link_clock,
   // settings
   input wire logic byte_sync_enable,
   input wire logic channelise_enable,
   input wire logic [CW-1:0] framing_gap_threshold,
   // status
   output logic framing_det,
   output logic byte_start
);
   logic s1_q, s2_q, s3_q, lvl_q;
   logic [1:0] edge_q;
   logic [CW-1:0] cnt_q;
   wire logic agree = (s2_q == s3_q);
   wire logic rise = agree & s3_q & ~lvl_q;
   wire logic det = (cnt_q > framing_gap_threshold);
   wire logic clr = rise & (~byte_sync_enable | (edge_q == `TSP_EDGE_LAST) | det);
   wire logic sat = &cnt_q;

   // three-stage synchroniser; a level is taken once stages two and three agree
   always_ff @(posedge clock) begin
      s1_q <= tx_link_clock;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (rst) begin
         lvl_q <= 1'b0;
      end else if (agree) begin
         lvl_q <= s3_q;
      end
   end

   // gap counter; saturates so a stopped clock keeps reporting a gap
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q <= '0;
         edge_q <= '0;
      end else begin
         cnt_q <= clr ? '0 : (sat ? cnt_q : cnt_q + 1'b1);
         edge_q <= clr ? '0 : (rise ? edge_q + 1'b1 : edge_q);
      end
   end

   assign framing_det = det;
   // first bit after a long quiet period starts a byte
   assign byte_start = rise & det & byte_sync_enable & ~channelise_enable;

   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   cnt_clear_a: assert property (rise & ~byte_sync_enable |=> cnt_q == '0)
      else $error("gap counter not cleared on link clock edge");
   // the reset level is part of the antecedent so the edge that releases reset starts no attempt
   cnt_inc_a: assert property (~rst & ~rise & ~sat |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("gap counter did not advance");
   quad_hold_a: assert property (rise & byte_sync_enable & edge_q != `TSP_EDGE_LAST & ~det
      |=> cnt_q != '0)
      else $error("gap counter cleared before fourth edge");
   // a count that steps past a steady threshold must show as a gap on the next cycle
   det_level_a: assert property (cnt_q == framing_gap_threshold & ~clr & ~sat
      ##1 $stable(framing_gap_threshold) |-> framing_det)
      else $error("gap above threshold not reported");
endmodule // tsp_link_mon

// ==== bench/tsp_link_gen.sv ====
// gapped transmit link clock source standing in for the downstream framer side
`timescale 1ns/1ps
module tsp_link_gen (
   // gap control
   input wire logic run,
   // link clock
   output logic tx_link_clock
);
   // ----------------------------------------
   // clock source
   // ----------------------------------------
   // 200 ns period while running, held low in gaps so the monitors see real quiet time;
   // the odd start offset keeps its phase unrelated to the system clock
   initial begin
      tx_link_clock = 1'b0;
      #37;
      forever begin
         wait (run === 1'b1);
         #100 tx_link_clock = 1'b1;
         #100 tx_link_clock = 1'b0;
      end
   end
endmodule // tsp_link_gen

// ==== bench/test_tsp_top.sv ====
// self-checking bench of the slot provisioning register bank
`timescale 1ns/1ps
`include "tsp_cfg.svh"
module test_tsp_top;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [31:0] framing_det;
   logic [31:0] byte_start;
   logic lk_valid = 1'b0;
   logic [4:0] lk_link = 5'h0;
   logic [4:0] lk_slot = 5'h0;
   logic [7:0] channel_number_byte = 8'h0;
   logic lk_out_valid;
   logic lk_assigned;
   logic [6:0] lk_channel;
   logic [7:0] tx_link_data;
   logic run = 1'b0;
   logic lclk;
   int n_mismatch = 0;
   int n_checks = 0;
   // ----------------------------------------
   // instances
   // ----------------------------------------
   always #12.5 clock = ~clock;
   tsp_link_gen tsp_link_gen_i (.run(run), .tx_link_clock(lclk));
   // links 0 and 1 share one source so the two monitor modes can be compared
   tsp_top tsp_top_i (
      .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .tx_link_clock({30'h0, lclk, lclk}), .framing_det(framing_det),
      .byte_start(byte_start), .lk_valid(lk_valid), .lk_link(lk_link), .lk_slot(lk_slot),
      .channel_number_byte(channel_number_byte), .lk_out_valid(lk_out_valid), .lk_assigned(lk_assigned),
      .lk_channel(lk_channel), .tx_link_data(tx_link_data));
   // ----------------------------------------
   // reporting and bus tasks
   // ----------------------------------------
   task automatic summarize();
      $display("mismatches %0d checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic hang(input string msg);
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s wait ran out", $time, msg);
      summarize();
   endtask
   // one single word transfer; the wait for hready is bounded, never assumed
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) hang("address phase");
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) hang("data phase");
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0, "response");
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      bus(1'b0, a, 32'h0, d);
   endtask
   // polls select until busy drops and counts the reads that saw it high
   task automatic poll(output int nb);
      logic [31:0] r;
      nb = 0;
      for (int i = 0; i < 20; i++) begin
         rd(`TSP_OFS_SEL, r);
         if (r[`TSP_BUSY_BIT] === 1'b0) return;
         nb++;
      end
      hang("busy");
   endtask
   function automatic logic [31:0] sel(input logic dir, input logic [4:0] l, input logic [4:0] s);
      return {16'h0, 1'b0, dir, 1'b0, l, 3'h0, s};
   endfunction
   task automatic slot_assigned_flag(input logic [4:0] l, input logic [4:0] s, input logic p, input logic [6:0] c);
      int nb;
      wr(`TSP_OFS_DATA, {23'h0, p, 1'b0, c});
      wr(`TSP_OFS_SEL, sel(1'b0, l, s));
      poll(nb);
   endtask
   task automatic fetch(input logic [4:0] l, input logic [4:0] s, input logic [31:0] exp);
      int nb;
      logic [31:0] r;
      wr(`TSP_OFS_SEL, sel(1'b1, l, s));
      poll(nb);
      chk((nb > 0) ? 32'h1 : 32'h0, 32'h1, "busy during read");
      rd(`TSP_OFS_DATA, r);
      chk(r, exp, "entry read back");
   endtask
   // lookup answer appears two edges after the request
   task automatic lk(input logic [4:0] l, input logic [4:0] s, input logic [7:0] b, input logic as,
                     input logic [6:0] ch, input logic [7:0] exp);
      lk_valid <= 1'b1;
      lk_link <= l;
      lk_slot <= s;
      channel_number_byte <= b;
      @(posedge clock);
      lk_valid <= 1'b0;
      @(posedge clock);
      #1;
      chk({22'h0, lk_out_valid, lk_assigned, tx_link_data}, {22'h0, 1'b1, as, exp}, "lookup");
      if (as) chk({25'h0, lk_channel}, {25'h0, ch}, "lookup channel");
      @(posedge clock);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [31:0] r;
      rd(`TSP_OFS_SEL, r);
      chk(r, 32'h0, "select reset");
      rd(`TSP_OFS_THR, r);
      chk(r, 32'h1F, "threshold reset");
      rd(`TSP_OFS_FILL, r);
      chk(r, 32'hFF, "fill reset");
      rd(12'h7F0, r);
      chk(r, 32'h0, "unmapped read");
   endtask
   task automatic t_indirect();
      logic [31:0] r;
      slot_assigned_flag(5'h03, 5'h05, 1'b1, 7'h2A);
      rd(`TSP_OFS_DATA, r);
      chk(r, 32'h12A, "data kept after write");
      slot_assigned_flag(5'h05, 5'h03, 1'b1, 7'h15);
      slot_assigned_flag(5'h1F, 5'h01, 1'b1, 7'h7F);
      slot_assigned_flag(5'h04, 5'h1F, 1'b1, 7'h11);
      slot_assigned_flag(5'h05, 5'h00, 1'b1, 7'h33);
      slot_assigned_flag(5'h03, 5'h02, 1'b0, 7'h44);
      fetch(5'h03, 5'h05, 32'h12A);
      fetch(5'h05, 5'h03, 32'h115);
      fetch(5'h1F, 5'h01, 32'h17F);
      fetch(5'h03, 5'h02, 32'h044);
   endtask
   // second select write lands while the read access still holds busy
   task automatic t_busy_ignore();
      int nb;
      logic [31:0] r;
      wr(`TSP_OFS_SEL, sel(1'b1, 5'h03, 5'h05));
      wr(`TSP_OFS_SEL, sel(1'b0, 5'h09, 5'h09));
      poll(nb);
      rd(`TSP_OFS_SEL, r);
      chk(r, sel(1'b1, 5'h03, 5'h05), "select kept while busy");
      rd(`TSP_OFS_DATA, r);
      chk(r, 32'h12A, "read result");
   endtask
   task automatic t_lookup();
      wr(`TSP_OFS_CEN, 32'h18);
      wr(`TSP_OFS_E1, 32'h10);
      wr(`TSP_OFS_FILL, 32'h7E);
      lk(5'h03, 5'h05, 8'h5A, 1'b1, 7'h2A, 8'h5A);
      lk(5'h03, 5'h02, 8'hA5, 1'b0, 7'h00, 8'h7E);
      lk(5'h03, 5'h19, 8'hA5, 1'b0, 7'h00, 8'h7E);
      lk(5'h04, 5'h1F, 8'hC3, 1'b1, 7'h11, 8'hC3);
      lk(5'h05, 5'h00, 8'h3C, 1'b1, 7'h33, 8'h3C);
      lk(5'h05, 5'h03, 8'h3C, 1'b0, 7'h00, 8'h7E);
   endtask
   // link 0 clears per clock rise, link 1 per four rises; both see the same clock
   task automatic t_monitor();
      int n0;
      int n1;
      int nb;
      // 20 cycles sits above the 8-cycle bit spacing and below a four-rise group
      wr(`TSP_OFS_THR, 32'h14);
      wr(`TSP_OFS_BYTE_SYNC_ENABLE, 32'h2);
      run <= 1'b1;
      repeat (40) @(posedge clock);
      n0 = 0;
      n1 = 0;
      repeat (64) begin
         @(posedge clock);
         #1;
         n0 += (framing_det[0] !== 1'b0);
         n1 += (framing_det[1] !== 1'b0);
      end
      chk(n0, 0, "no gap while clocking");
      chk((n1 > 0) ? 32'h1 : 32'h0, 32'h1, "four rise grouping");
      run <= 1'b0;
      repeat (50) @(posedge clock);
      #1;
      chk({31'h0, framing_det[0]}, 32'h1, "gap detected");
      run <= 1'b1;
      nb = 0;
      n1 = 0;
      repeat (30) begin
         @(posedge clock);
         #1;
         nb += (byte_start[1] === 1'b1);
         n1 += (byte_start[0] !== 1'b0);
      end
      chk((nb > 0) ? 32'h1 : 32'h0, 32'h1, "msb marker after gap");
      chk(n1, 0, "no marker without byte sync");
      chk({31'h0, framing_det[0]}, 32'h0, "gap cleared by clock");
      @(posedge clock);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_indirect();
      t_busy_ignore();
      t_lookup();
      t_monitor();
      summarize();
   end
endmodule // test_tsp_top
